// *** src/pssb_pkg.sv ***
package pssb_pkg;
  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W    = 15;
  localparam int DATA_W    = 36;
  localparam int LANES     = 4;
  localparam int LANE_W    = 9;
  localparam int DEPTH     = 32768;
  localparam int SEED_W    = 2;
  localparam int HI_W      = ADDR_W - SEED_W;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [SEED_W-1:0] SEED_RST  = 2'h0;
  localparam logic [HI_W-1:0]   HI_RST    = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RST  = 36'h0_0000_0000;
  localparam logic [LANES-1:0]  MASK_NONE = 4'h0;
  localparam logic [LANES-1:0]  MASK_ALL  = 4'hf;
endpackage

// *** src/pssb_burst_ctr.sv ***
`timescale 1ns/1ns
module pssb_burst_ctr
  import pssb_pkg::*;
(
  // Clock and control
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_en,
  // Burst control
  input  wire logic              i_load,
  input  wire logic [SEED_W-1:0] i_seed,
  input  wire logic              i_advance,
  input  wire logic              i_linear,
  // Low address bits of current access
  output logic      [SEED_W-1:0] o_low
);
  logic [SEED_W-1:0] seed_reg;
  logic [SEED_W-1:0] count_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      seed_reg  <= SEED_RST;
      count_reg <= SEED_RST;
    end
    else if (i_en)
    begin
      if (i_load)
      begin
        seed_reg  <= i_seed;
        count_reg <= SEED_RST;
      end
      else if (i_advance)
        count_reg <= count_reg + 2'h1;
    end
  end

  // Two-bit arithmetic wraps inside the four-word group
  assign o_low = i_linear ? seed_reg + count_reg : seed_reg ^ count_reg;
endmodule

// *** src/pssb_sram.sv ***
`timescale 1ns/1ns
module pssb_sram
  import pssb_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_ce,
  // Address and strobes
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_proc_addr_strobe_n,
  input  wire logic              i_ctrl_addr_strobe_n,
  input  wire logic              i_burst_advance_n,
  input  wire logic              i_burst_linear,
  // Chip selects
  input  wire logic              i_chip_sel_primary_n,
  input  wire logic              i_chip_sel_depth_hi,
  input  wire logic              i_chip_sel_depth_lo_n,
  // Write controls
  input  wire logic [LANES-1:0]  i_lane_write_sel_n,
  input  wire logic              i_lane_write_enable_n,
  input  wire logic              i_all_lanes_write_n,
  // Asynchronous controls
  input  wire logic              i_out_enable_n,
  input  wire logic              i_sleep_request,
  // Shared data bus
  input  wire logic [DATA_W-1:0] i_dq,
  output logic      [DATA_W-1:0] o_dq,
  output logic                   o_dq_oe
);
  // ---------------------------------------------------------------
  // Strobe decode
  // ---------------------------------------------------------------
  logic              en;
  logic              proc_strobe;
  logic              strobe;
  logic              chips_on;
  logic              load;
  logic              deselect;
  logic              wr_go;
  logic [LANES-1:0]  wr_mask;
  logic [SEED_W-1:0] low;
  logic [ADDR_W-1:0] cur_addr;
  logic [DATA_W-1:0] rd_word;

  logic [HI_W-1:0]   addr_hi_reg;
  logic              sel_reg;
  logic              wr_pend_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic [LANES-1:0]  wr_mask_reg;
  logic [DATA_W-1:0] o_dq_reg;
  logic              rd_valid_reg;
  logic              oe_mask_reg;
  logic              leave_reg;

  // Sleep freezes every state bit so the array content is kept
  assign en          = i_ce & ~i_sleep_request;
  assign proc_strobe = ~i_proc_addr_strobe_n & ~i_chip_sel_primary_n;
  assign strobe      = proc_strobe | ~i_ctrl_addr_strobe_n;
  assign chips_on    = ~i_chip_sel_primary_n & i_chip_sel_depth_hi
                       & ~i_chip_sel_depth_lo_n;
  assign load        = strobe & chips_on;
  assign deselect    = strobe & ~chips_on;

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  always_comb
  begin
    if (!i_all_lanes_write_n)
      wr_mask = MASK_ALL;
    else if (!i_lane_write_enable_n)
      wr_mask = ~i_lane_write_sel_n;
    else
      wr_mask = MASK_NONE;
  end

  // A processor-strobe start is always a read; writes follow it
  assign wr_go    = (load ? ~proc_strobe : sel_reg & ~deselect) & (wr_mask != MASK_NONE);
  assign cur_addr = load ? i_addr : {addr_hi_reg, low};

  // ---------------------------------------------------------------
  // Address and burst
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      addr_hi_reg <= HI_RST;
    else if (en && load)
      addr_hi_reg <= i_addr[ADDR_W-1:SEED_W];
  end

  pssb_burst_ctr u_ctr (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_en      (en),
    .i_load    (load),
    .i_seed    (i_addr[SEED_W-1:0]),
    .i_advance (sel_reg & ~i_burst_advance_n),
    .i_linear  (i_burst_linear),
    .o_low     (low)
  );

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      sel_reg <= 1'b0;
    else if (en && strobe)
      sel_reg <= chips_on;
  end

  // ---------------------------------------------------------------
  // Self-timed write
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= {ADDR_W{1'b0}};
      wr_data_reg <= DATA_RST;
      wr_mask_reg <= MASK_NONE;
    end
    else if (en)
    begin
      wr_pend_reg <= wr_go;
      wr_addr_reg <= cur_addr;
      wr_data_reg <= i_dq;
      wr_mask_reg <= wr_go ? wr_mask : MASK_NONE;
    end
  end

  // ---------------------------------------------------------------
  // Array, one bank per byte lane
  // ---------------------------------------------------------------
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    logic [LANE_W-1:0] bank [DEPTH];
    always_ff @(posedge i_clk)
    begin
      if (en && wr_pend_reg && wr_mask_reg[l])
        bank[wr_addr_reg] <= wr_data_reg[l*LANE_W +: LANE_W];
    end
    assign rd_word[l*LANE_W +: LANE_W] = bank[{addr_hi_reg, low}];
  end

  // ---------------------------------------------------------------
  // Read pipeline and output drive
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_dq_reg     <= DATA_RST;
      rd_valid_reg <= 1'b0;
    end
    else if (en)
    begin
      rd_valid_reg <= sel_reg & ~wr_go & ~load & ~deselect;
      if (sel_reg && !wr_go && !load && !deselect)
        o_dq_reg <= rd_word;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      leave_reg   <= 1'b0;
      oe_mask_reg <= 1'b0;
    end
    else if (en)
    begin
      // Mask lands on the first data cycle, not on the load cycle
      leave_reg   <= load & ~sel_reg;
      oe_mask_reg <= leave_reg;
    end
  end

  assign o_dq = o_dq_reg;
  // Pin direction follows the enable pins without a clock
  assign o_dq_oe = ~i_out_enable_n & ~i_sleep_request & rd_valid_reg
                   & ~oe_mask_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_wr_req;
    en && wr_go;
  endsequence

  sequence s_wr_commit;
    wr_pend_reg && (wr_addr_reg == $past(cur_addr));
  endsequence

  property p_load_addr;
    @(posedge i_clk) disable iff (i_rst)
    en && load |=> addr_hi_reg == $past(i_addr[ADDR_W-1:SEED_W]);
  endproperty
  a_load_addr : assert property (p_load_addr) else $error("address not loaded");

  property p_proc_ignored;
    @(posedge i_clk) disable iff (i_rst)
    en && i_chip_sel_primary_n && i_ctrl_addr_strobe_n |=> $stable(addr_hi_reg) && $stable(sel_reg);
  endproperty
  a_proc_ignored : assert property (p_proc_ignored) else $error("strobe not ignored");

  property p_advance;
    @(posedge i_clk) disable iff (i_rst)
    en && sel_reg && !strobe && !i_burst_advance_n && i_burst_linear
      |=> low == $past(low) + 2'h1;
  endproperty
  a_advance : assert property (p_advance) else $error("burst did not advance");

  property p_hold;
    @(posedge i_clk) disable iff (i_rst)
    en && !strobe && i_burst_advance_n && $stable(i_burst_linear)
      |=> $stable(low) && $stable(addr_hi_reg);
  endproperty
  a_hold : assert property (p_hold) else $error("burst moved without advance");

  property p_write_commit;
    @(posedge i_clk) disable iff (i_rst)
    s_wr_req |=> s_wr_commit;
  endproperty
  a_write_commit : assert property (p_write_commit) else $error("write not staged");

  property p_global_write;
    @(posedge i_clk) disable iff (i_rst)
    en && wr_go && !i_all_lanes_write_n |=> wr_mask_reg == MASK_ALL;
  endproperty
  a_global_write : assert property (p_global_write) else $error("global write not all lanes");

  property p_no_byte_write;
    @(posedge i_clk) disable iff (i_rst)
    en && i_all_lanes_write_n && i_lane_write_enable_n |=> !wr_pend_reg;
  endproperty
  a_no_byte_write : assert property (p_no_byte_write) else $error("write without enable");

  property p_oe_float;
    @(posedge i_clk) disable iff (i_rst)
    i_out_enable_n || i_sleep_request |-> !o_dq_oe;
  endproperty
  a_oe_float : assert property (p_oe_float) else $error("bus driven while disabled");

  sequence s_leave_desel;
    en && load && !sel_reg;
  endsequence

  property p_first_mask;
    @(posedge i_clk) disable iff (i_rst)
    s_leave_desel ##1 en |=> !o_dq_oe;
  endproperty
  a_first_mask : assert property (p_first_mask) else $error("OE not masked");

  property p_read_latency;
    @(posedge i_clk) disable iff (i_rst)
    en && sel_reg && !wr_go && !strobe |=> rd_valid_reg && o_dq === $past(rd_word);
  endproperty
  a_read_latency : assert property (p_read_latency) else $error("read data late");

  property p_sleep_hold;
    @(posedge i_clk) disable iff (i_rst)
    i_sleep_request |=> $stable(sel_reg) && $stable(o_dq) && $stable(wr_pend_reg);
  endproperty
  a_sleep_hold : assert property (p_sleep_hold) else $error("state moved in sleep");
endmodule

// *** tb/pssb_host_bus.sv ***
`timescale 1ns/1ns
module pssb_host_bus
  import pssb_pkg::*;
(
  // Clock
  input  wire logic              i_clk,
  // Host and device drivers
  input  wire logic [DATA_W-1:0] i_host_dq,
  input  wire logic              i_host_oe,
  input  wire logic [DATA_W-1:0] i_dev_dq,
  input  wire logic              i_dev_oe,
  // Resolved data bus
  output logic      [DATA_W-1:0] o_bus
);
  logic [DATA_W-1:0] last_reg = DATA_RST;
  // Released bus toggles so stale data never looks valid
  always_comb
  begin
    if (i_dev_oe)
      o_bus = i_dev_dq;
    else if (i_host_oe)
      o_bus = i_host_dq;
    else
      o_bus = ~last_reg;
  end
  always_ff @(posedge i_clk)
  begin
    last_reg <= o_bus;
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ns
module tb
  import pssb_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic              clk, rst, pstb_n, cstb_n, step_n, lin, sel_p_n, sel_h;
  logic              sel_l_n, lane_en_n, all_n, oe_n, slp, host_oe, dq_oe, ce;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0]  lane_n;
  logic [DATA_W-1:0] dq_h, bus, dq_o;
  logic [DATA_W-1:0] mem [int];
  logic [31:0]       seed = 32'ha41d82c2;
  int                fails = 0;
  int                n_checks = 0;
  pssb_sram i_pssb_sram (
    .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_addr(addr),
    .i_proc_addr_strobe_n(pstb_n), .i_ctrl_addr_strobe_n(cstb_n),
    .i_burst_advance_n(step_n), .i_burst_linear(lin),
    .i_chip_sel_primary_n(sel_p_n), .i_chip_sel_depth_hi(sel_h),
    .i_chip_sel_depth_lo_n(sel_l_n), .i_lane_write_sel_n(lane_n),
    .i_lane_write_enable_n(lane_en_n), .i_all_lanes_write_n(all_n),
    .i_out_enable_n(oe_n), .i_sleep_request(slp), .i_dq(bus),
    .o_dq(dq_o), .o_dq_oe(dq_oe)
  );
  pssb_host_bus i_pssb_host_bus (
    .i_clk(clk), .i_host_dq(dq_h), .i_host_oe(host_oe),
    .i_dev_dq(dq_o), .i_dev_oe(dq_oe), .o_bus(bus)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] idx(input logic [1:0] s, c, input logic l);
    return l ? s + c : s ^ c;
  endfunction
  task automatic tick();
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic idle();
    {pstb_n, cstb_n, step_n, all_n, lane_en_n, sel_h} = 6'h3f;
    {sel_p_n, sel_l_n, host_oe, oe_n} = 4'h0;
    lane_n = 4'hf;
  endtask
  task automatic chk_d(input logic [DATA_W-1:0] got, exp);
    n_checks++;
    if (got !== exp)
      $display("unexpected data at %0t: got %h exp %h", $time, got, exp);
    if (got !== exp)
      fails++;
  endtask
  task automatic chk_b(input logic got, exp);
    n_checks++;
    if (got !== exp)
      $display("unexpected drive at %0t: got %h exp %h", $time, got, exp);
    if (got !== exp)
      fails++;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic both);
    {cstb_n, pstb_n, all_n, host_oe, oe_n} = {1'b0, ~both, 3'h3};
    {lane_n, lane_en_n} = 5'(rnd());
    addr = a;
    dq_h = d;
    tick();
    if (!both)
      mem[a] = d;
    idle();
    tick();
  endtask
  task automatic bw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [LANES-1:0] m, input logic en_n);
    pstb_n = 1'b0;
    addr = a;
    tick();
    {pstb_n, lane_n, lane_en_n, host_oe, oe_n} = {1'b1, m, en_n, 2'h3};
    dq_h = d;
    tick();
    for (int l = 0; l < LANES; l++)
      if (!en_n && !m[l])
        mem[a][l*LANE_W +: LANE_W] = d[l*LANE_W +: LANE_W];
    idle();
    tick();
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic l, input int hold);
    logic [1:0]        c;
    logic [DATA_W-1:0] w;
    c = 2'h0;
    {cstb_n, sel_p_n} = 2'h1;
    tick();
    {sel_p_n, addr, lin} = {1'b0, a, l};
    tick();
    cstb_n = 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      step_n = (j == hold);
      tick();
      chk_d(dq_o, mem[{a[ADDR_W-1:2], idx(a[1:0], c, l)}]);
      chk_b(dq_oe, j != 0);
      c = c + 2'(j != hold);
    end
    w = mem[{a[ADDR_W-1:2], idx(a[1:0], c, l)}];
    {pstb_n, sel_p_n, step_n, addr} = {3'h3, a ^ 15'h0004};
    tick();
    idle();
    tick();
    chk_d(dq_o, w);
    oe_n = 1'b1;
    #1 chk_b(dq_oe, 1'b0);
    {oe_n, slp, step_n} = 3'h2;
    #1 chk_b(dq_oe, 1'b0);
    tick();
    slp = 1'b0;
    #1 chk_b(dq_oe, 1'b1);
    chk_d(dq_o, w);
    {cstb_n, sel_l_n, sel_h, ce} = {1'b0, l, l, 1'b0};
    tick();
    chk_b(dq_oe, 1'b1);
    chk_d(dq_o, w);
    ce = 1'b1;
    tick();
    idle();
    tick();
    chk_b(dq_oe, 1'b0);
  endtask
  // ---------------------------------------------------------------
  // Sequence and verdict
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    logic [ADDR_W-1:0] base;
    {rst, lin, oe_n, slp, ce, addr, dq_h} = {5'h11, 15'h0000, DATA_RST};
    idle();
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    tick();
    for (int t = 0; t < 12; t++)
    begin
      base = 15'(rnd()) & 15'h7ffc;
      for (int k = 0; k < 4; k++)
        wr(base | 15'(k), 36'({rnd(), rnd()}), 1'b0);
      if (t < 3)
        wr(base | 15'h0002, 36'({rnd(), rnd()}), 1'b1);
      bw(base | 15'(rnd() % 4), 36'({rnd(), rnd()}), 4'(rnd()), 1'(rnd()));
      if (t < 2)
        bw(base | 15'h0001, 36'({rnd(), rnd()}), 4'h0, 1'b1);
      rd(base | 15'(rnd() % 4), t[0], t < 2 ? 4 : int'(1 + rnd() % 4));
    end
    stop_test();
  end
  // Run takes about 300 cycles; the limit allows over thirteen times that
  initial
  begin
    #40000;
    fails++;
    stop_test();
  end
endmodule
